// >>> verilog/wake_irq_pkg.sv
// constants, register map and bit layout of the wake and interrupt unit
// assumes a single 100 MHz clock domain and a plain register port
package wake_irq_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int NUM_LINES = 20;
  localparam int TIMERS_DEF = 9;
  localparam int WT_W = 32;
  localparam int PC_W = 16;
  localparam int AP_W = 5;
  localparam int CLK_HZ = 100000000;
  localparam int SLOW_HZ = 32768;
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP, ST_WOKEN} pwr_state_t;
  // register indices on the plain register port
  localparam addr_t A_SYS_STAT = 5'h00;
  localparam addr_t A_SYS_EN = 5'h01;
  localparam addr_t A_DL_DIR = 5'h02;
  localparam addr_t A_DL_OUT = 5'h03;
  localparam addr_t A_DL_WEN = 5'h04;
  localparam addr_t A_DL_EDGE = 5'h05;
  localparam addr_t A_DL_IN = 5'h06;
  localparam addr_t A_COMP_CFG = 5'h07;
  localparam addr_t A_WT0 = 5'h08;
  localparam addr_t A_PC0 = 5'h0A;
  localparam addr_t A_CAUSE = 5'h0C;
  localparam addr_t A_CNT_STAT = 5'h0D;
  localparam addr_t A_AP_STAT = 5'h0E;
  localparam addr_t A_AP_EN = 5'h0F;
  localparam addr_t A_AP_MODE = 5'h10;
  localparam addr_t A_TMR_EN = 5'h11;
  localparam addr_t A_TMR_STAT0 = 5'h12;
  // system-controller bitmap positions
  localparam int B_CLK_CHG = 31;
  localparam int B_RNG = 30;
  localparam int B_COMP0 = 28;
  localparam int B_WT0 = 26;
  localparam int B_BO_IN = 25;
  localparam int B_BO_OUT = 24;
  localparam int B_PC0 = 22;
  localparam int B_LINE0 = 0;
  localparam word_t WAKE_MASK = 32'h3CCF_FFFF;
  // analogue and timer bitmap positions
  localparam int B_AP_ACC = 1;
  localparam int B_T_RISE = 1;
  localparam int B_T_PER = 0;
  localparam logic [NUM_LINES-1:0] DIR_RESET = 20'h0_0000;
endpackage

// >>> verilog/count_if.sv
// carrier between the unit and its slow counters
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface count_if #(parameter int W = 32);
  logic load;
  logic [W-1:0] load_val;
  logic tick;
  logic hit;
  logic [W-1:0] count;
  logic flag;
  modport ctl (output load, load_val, tick, input hit, count, flag);
  modport cnt (input load, load_val, tick, output hit, count, flag);
endinterface

// >>> verilog/wake_timer.sv
// one wake timer: down-counter on the slow tick, fired flag
// assumes the tick is a one-cycle enable at the nominal slow rate
`timescale 1ns/1ps
module wake_timer (
  // clock and control
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // counter side
  count_if.cnt c
);
  logic running_reg;
  logic hit_reg;
  logic fired_reg;
  logic [$bits(c.count)-1:0] count_reg;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      count_reg <= '0;
      running_reg <= 1'b0;
      fired_reg <= 1'b0;
      hit_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      hit_reg <= 1'b0;
      if (c.load)
      begin
        count_reg <= c.load_val;
        running_reg <= |c.load_val;
        fired_reg <= 1'b0;
      end
      else if (c.tick && running_reg)
      begin
        count_reg <= count_reg - 1'b1;
        if (count_reg == 1)
        begin
          running_reg <= 1'b0;
          fired_reg <= 1'b1;
          hit_reg <= 1'b1;
        end
      end
    end
  end

  assign c.hit = hit_reg;
  assign c.count = count_reg;
  assign c.flag = fired_reg;

  a_fired_after_hit: assert property (@(posedge clk_i) disable iff (srst_i)
    hit_reg && ce_i && !c.load |=> fired_reg)
    else $error("fired flag not set after expiry");
endmodule

// >>> verilog/pulse_counter.sv
// one pulse counter: counts pulses up to a reference, then wraps
// assumes the tick is a one-cycle pulse per counted edge
`timescale 1ns/1ps
module pulse_counter (
  // clock and control
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // counter side
  count_if.cnt c
);
  logic hit_reg;
  logic [$bits(c.count)-1:0] count_reg;
  logic [$bits(c.count)-1:0] ref_reg;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      count_reg <= '0;
      ref_reg <= '0;
      hit_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      hit_reg <= 1'b0;
      if (c.load)
      begin
        ref_reg <= c.load_val;
        count_reg <= '0;
      end
      else if (c.tick && ref_reg != 0)
      begin
        if (count_reg + 1'b1 == ref_reg)
        begin
          count_reg <= '0;
          hit_reg <= 1'b1;
        end
        else
          count_reg <= count_reg + 1'b1;
      end
    end
  end

  assign c.hit = hit_reg;
  assign c.count = count_reg;
  assign c.flag = |ref_reg;

  a_ref_reached: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && c.tick && !c.load && ref_reg != 0
    && count_reg + 1'b1 == ref_reg |=> hit_reg && count_reg == 0)
    else $error("reference count reached without event");
endmodule

// >>> verilog/wake_irq_unit.sv
// wake and interrupt status unit: sticky bitmaps, wake logic, counters
// assumes synchronous inputs, a slow tick enable and a plain reg port
//
// What this block does
// - wake on timer, line, comparator or counter
// - only sources enabled before sleep wake
// - pending status stays until software clears
// - wake cause readable until pending cleared
// - two wake timers on slow clock
// - enabled timer expiry raises wake interrupt
// - per-timer fired indication readable
// - twenty lines with programmable direction
// - line wakes only as enabled input
// - per-line edge select, wake status per line
// - comparator rise or fall events, flagged
// - two pulse counters hit reference count
// - causes reported as 32-bit bitmaps
// - bit 31 clock change, 30 random
// - comparators bits 29:28, timers 27:26
// - brownout entry bit 25, exit 24
// - pulse counters at bits 23 and 22
// - line flags at their line number
// - buffer overflow 4, full 3, half 2
// - accumulation done bit 1, conversion 0
// - timer rising edge sets bit 1
// - timer period end sets bit 0
// - software can clear status before handler
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module wake_irq_unit #(
  parameter int NUM_TIMERS = wake_irq_pkg::TIMERS_DEF
) (
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  // register port
  input wire logic [wake_irq_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [wake_irq_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [wake_irq_pkg::DATA_W-1:0] RDATA_O,
  // power control
  input wire logic SLOW_TICK_I,
  input wire logic SLEEP_I,
  output logic WAKE_O,
  // digital lines
  input wire logic [wake_irq_pkg::NUM_LINES-1:0] DL_IN_I,
  output logic [wake_irq_pkg::NUM_LINES-1:0] DL_OUT_O,
  output logic [wake_irq_pkg::NUM_LINES-1:0] DL_OE_O,
  // event sources
  input wire logic [1:0] COMP_I,
  input wire logic [1:0] PULSE_I,
  input wire logic CLK_CHG_I,
  input wire logic RNG_NEW_I,
  input wire logic BROWNOUT_I,
  input wire logic [wake_irq_pkg::AP_W-1:0] AP_EVT_I,
  input wire logic [NUM_TIMERS-1:0] TMR_OUT_I,
  // interrupt requests: system, analogue, then one per timer
  output logic [NUM_TIMERS+1:0] IRQ_O
);
  import wake_irq_pkg::*;

  //----------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------
  pwr_state_t state_reg;
  word_t sys_stat_reg;
  word_t sys_en_reg;
  word_t sleep_en_reg;
  word_t cause_reg;
  word_t sys_set;
  word_t wake_req;
  logic [NUM_LINES-1:0] dl_dir_reg;
  logic [NUM_LINES-1:0] dl_out_reg;
  logic [NUM_LINES-1:0] dl_wen_reg;
  logic [NUM_LINES-1:0] dl_edge_reg;
  logic [NUM_LINES-1:0] dl_d_reg;
  logic [NUM_LINES-1:0] line_evt;
  logic [3:0] comp_cfg_reg;
  logic [1:0] comp_d_reg;
  logic [1:0] pulse_d_reg;
  logic bo_d_reg;
  logic [AP_W-1:0] ap_stat_reg;
  logic [AP_W-1:0] ap_en_reg;
  logic [AP_W-1:0] ap_set;
  logic ap_mode_reg;
  logic [2*NUM_TIMERS-1:0] tmr_en_reg;
  logic [NUM_TIMERS-1:0][1:0] tmr_stat_reg;
  logic [NUM_TIMERS-1:0] tmr_d_reg;
  logic [1:0][WT_W-1:0] wt_cnt;
  logic [1:0][PC_W-1:0] pc_cnt;
  logic [1:0] wt_hit;
  logic [1:0] pc_hit;
  logic [1:0] wt_fired;
  logic [1:0] pc_armed;
  logic wr;
  logic rd;
  logic sys_wr;
  logic ap_wr;
  addr_t tmr_idx;

  assign wr = WR_I && CE_I;
  assign rd = RD_I && CE_I;
  assign sys_wr = wr && ADDR_I == A_SYS_STAT;
  assign ap_wr = wr && ADDR_I == A_AP_STAT;
  assign tmr_idx = ADDR_I - A_TMR_STAT0;

  //----------------------------------------------------------------
  // slow counters
  //----------------------------------------------------------------
  count_if #(.W(WT_W)) wt_if[2] ();
  count_if #(.W(PC_W)) pc_if[2] ();

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_cnt
      assign wt_if[g].load = wr && ADDR_I == A_WT0 + addr_t'(g);
      assign wt_if[g].load_val = WDATA_I[WT_W-1:0];
      assign wt_if[g].tick = SLOW_TICK_I;
      assign wt_hit[g] = wt_if[g].hit;
      assign wt_cnt[g] = wt_if[g].count;
      assign wt_fired[g] = wt_if[g].flag;
      wake_timer u_wt (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .ce_i(CE_I),
        .c(wt_if[g])
      );
      assign pc_if[g].load = wr && ADDR_I == A_PC0 + addr_t'(g);
      assign pc_if[g].load_val = WDATA_I[PC_W-1:0];
      assign pc_if[g].tick = PULSE_I[g] && !pulse_d_reg[g];
      assign pc_hit[g] = pc_if[g].hit;
      assign pc_cnt[g] = pc_if[g].count;
      assign pc_armed[g] = pc_if[g].flag;
      pulse_counter u_pc (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .ce_i(CE_I),
        .c(pc_if[g])
      );
    end
  endgenerate

  //----------------------------------------------------------------
  // digital line events
  //----------------------------------------------------------------
  generate
    for (g = 0; g < NUM_LINES; g++)
    begin : g_line
      // input only when not driven, wake enable, chosen edge
      assign line_evt[g] = !dl_dir_reg[g] && dl_wen_reg[g]
        && (dl_edge_reg[g] ? (DL_IN_I[g] && !dl_d_reg[g])
        : (!DL_IN_I[g] && dl_d_reg[g]));
    end
  endgenerate

  //----------------------------------------------------------------
  // event set vectors
  //----------------------------------------------------------------
  always_comb
  begin
    sys_set = '0;
    sys_set[B_CLK_CHG] = CLK_CHG_I;
    sys_set[B_RNG] = RNG_NEW_I;
    for (int c = 0; c < 2; c++)
    begin
      sys_set[B_COMP0+c] =
        (COMP_I[c] && !comp_d_reg[c] && comp_cfg_reg[2*c])
        || (!COMP_I[c] && comp_d_reg[c] && comp_cfg_reg[2*c+1]);
      sys_set[B_WT0+c] = wt_hit[c];
      sys_set[B_PC0+c] = pc_hit[c];
    end
    sys_set[B_BO_IN] = BROWNOUT_I && !bo_d_reg;
    sys_set[B_BO_OUT] = !BROWNOUT_I && bo_d_reg;
    sys_set[B_LINE0 +: NUM_LINES] = line_evt;
    ap_set = AP_EVT_I;
    ap_set[B_AP_ACC] = AP_EVT_I[B_AP_ACC] && ap_mode_reg;
  end

  //----------------------------------------------------------------
  // input history for edge detection
  //----------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      dl_d_reg <= '0;
      comp_d_reg <= '0;
      pulse_d_reg <= '0;
      bo_d_reg <= 1'b0;
      tmr_d_reg <= '0;
    end
    else if (CE_I)
    begin
      dl_d_reg <= DL_IN_I;
      comp_d_reg <= COMP_I;
      pulse_d_reg <= PULSE_I;
      bo_d_reg <= BROWNOUT_I;
      tmr_d_reg <= TMR_OUT_I;
    end
  end

  //----------------------------------------------------------------
  // sticky status, set wins over write-one clear
  //----------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      sys_stat_reg <= '0;
      ap_stat_reg <= '0;
    end
    else if (CE_I)
    begin
      sys_stat_reg <= (sys_stat_reg
        & ~(sys_wr ? WDATA_I : '0)) | sys_set;
      ap_stat_reg <= (ap_stat_reg
        & ~(ap_wr ? WDATA_I[AP_W-1:0] : '0)) | ap_set;
    end
  end

  generate
    for (g = 0; g < NUM_TIMERS; g++)
    begin : g_tmr
      always_ff @(posedge CLK_I)
      begin
        if (SRST_I)
          tmr_stat_reg[g] <= '0;
        else if (CE_I)
        begin
          tmr_stat_reg[g] <= (tmr_stat_reg[g] & ~((wr
            && ADDR_I == A_TMR_STAT0 + addr_t'(g)) ? WDATA_I[1:0]
            : 2'h0)) | {
            TMR_OUT_I[g] && !tmr_d_reg[g]
              && tmr_en_reg[2*g+B_T_RISE],
            !TMR_OUT_I[g] && tmr_d_reg[g]
              && tmr_en_reg[2*g+B_T_PER]};
        end
      end
      assign IRQ_O[2+g] = |(tmr_stat_reg[g]
        & tmr_en_reg[2*g +: 2]);
    end
  endgenerate

  assign IRQ_O[0] = |(sys_stat_reg & sys_en_reg);
  assign IRQ_O[1] = |(ap_stat_reg & ap_en_reg);

  //----------------------------------------------------------------
  // configuration registers
  //----------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      sys_en_reg <= '0;
      dl_dir_reg <= DIR_RESET;
      dl_out_reg <= '0;
      dl_wen_reg <= '0;
      dl_edge_reg <= '0;
      comp_cfg_reg <= '0;
      ap_en_reg <= '0;
      ap_mode_reg <= 1'b0;
      tmr_en_reg <= '0;
    end
    else if (wr)
    begin
      if (ADDR_I == A_SYS_EN)
        sys_en_reg <= WDATA_I;
      else if (ADDR_I == A_DL_DIR)
        dl_dir_reg <= WDATA_I[NUM_LINES-1:0];
      else if (ADDR_I == A_DL_OUT)
        dl_out_reg <= WDATA_I[NUM_LINES-1:0];
      else if (ADDR_I == A_DL_WEN)
        dl_wen_reg <= WDATA_I[NUM_LINES-1:0];
      else if (ADDR_I == A_DL_EDGE)
        dl_edge_reg <= WDATA_I[NUM_LINES-1:0];
      else if (ADDR_I == A_COMP_CFG)
        comp_cfg_reg <= WDATA_I[3:0];
      else if (ADDR_I == A_AP_EN)
        ap_en_reg <= WDATA_I[AP_W-1:0];
      else if (ADDR_I == A_AP_MODE)
        ap_mode_reg <= WDATA_I[0];
      else if (ADDR_I == A_TMR_EN)
        tmr_en_reg <= WDATA_I[2*NUM_TIMERS-1:0];
    end
  end

  assign DL_OUT_O = dl_out_reg;
  assign DL_OE_O = dl_dir_reg;

  //----------------------------------------------------------------
  // sleep and wake
  //----------------------------------------------------------------
  assign wake_req = sys_stat_reg & sleep_en_reg & WAKE_MASK;

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      state_reg <= ST_AWAKE;
      sleep_en_reg <= '0;
    end
    else if (CE_I)
    begin
      case (state_reg)
        ST_AWAKE:
          if (SLEEP_I)
          begin
            state_reg <= ST_SLEEP;
            sleep_en_reg <= sys_en_reg;
          end
        ST_SLEEP:
          if (|wake_req)
            state_reg <= ST_WOKEN;
          else if (!SLEEP_I)
            state_reg <= ST_AWAKE;
        ST_WOKEN:
          if (!SLEEP_I)
            state_reg <= ST_AWAKE;
        default:
          state_reg <= ST_AWAKE;
      endcase
    end
  end

  assign WAKE_O = state_reg == ST_WOKEN;

  // wake cause survives until the pending bits are cleared
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      cause_reg <= '0;
    else if (CE_I)
    begin
      if (state_reg == ST_SLEEP && |wake_req)
        cause_reg <= wake_req;
      else if (sys_wr)
        cause_reg <= cause_reg & ~WDATA_I;
    end
  end

  //----------------------------------------------------------------
  // read port, data in the cycle after the strobe, zero otherwise, held while CE_I is low
  //----------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      RDATA_O <= '0;
    else if (!CE_I)
      RDATA_O <= RDATA_O;
    else if (!rd)
      RDATA_O <= '0;
    else if (ADDR_I == A_SYS_STAT)
      RDATA_O <= sys_stat_reg;
    else if (ADDR_I == A_SYS_EN)
      RDATA_O <= sys_en_reg;
    else if (ADDR_I == A_DL_DIR)
      RDATA_O <= word_t'(dl_dir_reg);
    else if (ADDR_I == A_DL_OUT)
      RDATA_O <= word_t'(dl_out_reg);
    else if (ADDR_I == A_DL_WEN)
      RDATA_O <= word_t'(dl_wen_reg);
    else if (ADDR_I == A_DL_EDGE)
      RDATA_O <= word_t'(dl_edge_reg);
    else if (ADDR_I == A_DL_IN)
      RDATA_O <= word_t'(DL_IN_I);
    else if (ADDR_I == A_COMP_CFG)
      RDATA_O <= word_t'(comp_cfg_reg);
    else if (ADDR_I == A_WT0 || ADDR_I == A_WT0 + 5'h01)
      RDATA_O <= word_t'(wt_cnt[ADDR_I[0]]);
    else if (ADDR_I == A_PC0 || ADDR_I == A_PC0 + 5'h01)
      RDATA_O <= word_t'(pc_cnt[ADDR_I[0]]);
    else if (ADDR_I == A_CAUSE)
      RDATA_O <= cause_reg;
    else if (ADDR_I == A_CNT_STAT)
      RDATA_O <= word_t'({pc_armed, wt_fired});
    else if (ADDR_I == A_AP_STAT)
      RDATA_O <= word_t'(ap_stat_reg);
    else if (ADDR_I == A_AP_EN)
      RDATA_O <= word_t'(ap_en_reg);
    else if (ADDR_I == A_AP_MODE)
      RDATA_O <= word_t'(ap_mode_reg);
    else if (ADDR_I == A_TMR_EN)
      RDATA_O <= word_t'(tmr_en_reg);
    else if (ADDR_I >= A_TMR_STAT0
      && tmr_idx < addr_t'(NUM_TIMERS))
      RDATA_O <= word_t'(tmr_stat_reg[tmr_idx]);
    else
      RDATA_O <= '0;
  end

  //----------------------------------------------------------------
  // checks
  //----------------------------------------------------------------
  a_wake_on_source: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && state_reg == ST_SLEEP && |wake_req |=> WAKE_O)
    else $error("enabled pending source did not wake");

  a_wake_needs_en: assert property (@(posedge CLK_I) disable iff (SRST_I)
    $rose(WAKE_O) |-> |($past(sys_stat_reg) & sleep_en_reg))
    else $error("wake without an enabled source");

  a_status_sticky: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && !sys_wr |=> (sys_stat_reg & $past(sys_stat_reg))
    == $past(sys_stat_reg))
    else $error("status bit lost without a clear");

  a_cause_held: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && !sys_wr && state_reg != ST_SLEEP |=> $stable(cause_reg))
    else $error("wake cause changed without a clear");

  a_set_beats_clr: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && sys_wr && sys_set[B_CLK_CHG] |=> sys_stat_reg[B_CLK_CHG])
    else $error("event lost against a clear");

  a_brownout_in: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && BROWNOUT_I && !bo_d_reg |=> sys_stat_reg[B_BO_IN]
    ##1 !CE_I || sys_stat_reg[B_BO_IN] || $past(sys_wr))
    else $error("brownout entry not flagged");

  a_line_gated: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I |=> ((sys_stat_reg[NUM_LINES-1:0]
    & ~$past(sys_stat_reg[NUM_LINES-1:0]))
    & ($past(dl_dir_reg) | ~$past(dl_wen_reg))) == '0)
    else $error("line flag set for output or disabled line");

  a_acc_mode: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && !ap_mode_reg && !ap_stat_reg[B_AP_ACC]
    |=> !ap_stat_reg[B_AP_ACC])
    else $error("accumulation flag outside accumulation mode");

  a_tmr_rise: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && TMR_OUT_I[0] && !tmr_d_reg[0] && tmr_en_reg[B_T_RISE]
    |=> tmr_stat_reg[0][B_T_RISE] && IRQ_O[2])
    else $error("timer rising edge not flagged");
endmodule

// >>> testbench/line_pins.sv
// partner model: the board around the twenty digital line pins
// assumes the far device drives ext_i whenever a line is an input
`timescale 1ns/1ps
module line_pins (
  // pin controls from the unit
  input wire logic [wake_irq_pkg::NUM_LINES-1:0] oe_i,
  input wire logic [wake_irq_pkg::NUM_LINES-1:0] out_i,
  // far device levels
  input wire logic [wake_irq_pkg::NUM_LINES-1:0] ext_i,
  // resolved pin levels
  output logic [wake_irq_pkg::NUM_LINES-1:0] pin_o
);
  import wake_irq_pkg::*;
  // an output line shows its own data, an input line the far level
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// >>> testbench/testbench.sv
// self-checking bench: register calls with expected bitmaps
// assumes the unit, its counters and the pin model are compiled first
`timescale 1ns/1ps
module testbench;
  import wake_irq_pkg::*;
  logic clk = 0, srst = 1, wr = 0, rd = 0, tick = 0, sleep = 0;
  logic clk_chg = 0, rng = 0, bo = 0;
  addr_t addr = '0;
  word_t wdata = '0, rdata;
  logic [1:0] comp = '0, pulse = '0;
  logic [AP_W-1:0] ap = '0;
  logic [1:0] tmr = '0;
  logic [NUM_LINES-1:0] ext = '0, pins, dl_out, dl_oe;
  logic wake;
  logic [3:0] irq;
  int num_errors = 0, checks_done = 0;
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // design and pins
  // ----------------------------------------------------------------
  wake_irq_unit #(.NUM_TIMERS(2)) DUT (.CLK_I(clk), .SRST_I(srst),
    .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .SLOW_TICK_I(tick), .SLEEP_I(sleep), .WAKE_O(wake),
    .DL_IN_I(pins), .DL_OUT_O(dl_out), .DL_OE_O(dl_oe), .COMP_I(comp),
    .PULSE_I(pulse), .CLK_CHG_I(clk_chg), .RNG_NEW_I(rng),
    .BROWNOUT_I(bo), .AP_EVT_I(ap), .TMR_OUT_I(tmr), .IRQ_O(irq));
  line_pins board (.oe_i(dl_oe), .out_i(dl_out), .ext_i(ext),
    .pin_o(pins));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task cmp(input word_t got, input word_t exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrr(input addr_t a, input word_t d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdc(input addr_t a, input word_t e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata, e);
  endtask
  task tally_and_finish;
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    tk(6);
    srst <= 1'b0;
    rdc(A_SYS_STAT, 32'h0);
    rdc(5'h1F, 32'h0);
    rdc(A_DL_DIR, 32'h0);
    // line 3 rising, line 5 an output, line 19 falling
    wrr(A_DL_EDGE, 32'h8);
    wrr(A_DL_WEN, 32'h8_0028);
    wrr(A_DL_DIR, 32'h20);
    wrr(A_SYS_EN, 32'h8);
    wrr(A_DL_OUT, 32'h20);
    #1 cmp({12'h0, dl_oe}, 32'h20);
    ext <= 20'h8_0008;
    tk(3);
    rdc(A_SYS_STAT, 32'h8);
    #1 cmp({31'h0, irq[0]}, 32'h1);
    ext <= 20'h0;
    tk(3);
    rdc(A_SYS_STAT, 32'h8_0008);
    wrr(A_SYS_STAT, 32'h8);
    rdc(A_SYS_STAT, 32'h8_0000);
    #1 cmp({31'h0, irq[0]}, 32'h0);
    wrr(A_SYS_STAT, 32'hFFFF_FFFF);
    // system events in one burst
    wrr(A_COMP_CFG, 32'h4);
    clk_chg <= 1'b1;
    rng <= 1'b1;
    comp <= 2'b10;
    bo <= 1'b1;
    tk(1);
    clk_chg <= 1'b0;
    rng <= 1'b0;
    bo <= 1'b0;
    tk(2);
    comp <= 2'b00;
    tk(2);
    rdc(A_SYS_STAT, 32'hE300_0000);
    wrr(A_SYS_STAT, 32'hFFFF_FFFF);
    // pulse counter 0 hits a reference of two
    wrr(A_PC0, 32'h2);
    repeat (2)
    begin
      pulse <= 2'b01;
      tk(2);
      pulse <= 2'b00;
      tk(2);
    end
    rdc(A_SYS_STAT, 32'h0040_0000);
    wrr(A_SYS_STAT, 32'hFFFF_FFFF);
    // sleep, woken by wake timer 0 only
    wrr(A_SYS_EN, 32'h0400_0000);
    wrr(A_WT0, 32'h2);
    sleep <= 1'b1;
    ext <= 20'h8;
    tk(5);
    #1 cmp({31'h0, wake}, 32'h0);
    repeat (2)
    begin
      tick <= 1'b1;
      tk(1);
      tick <= 1'b0;
      tk(2);
    end
    tk(2);
    #1 cmp({31'h0, wake}, 32'h1);
    rdc(A_CAUSE, 32'h0400_0000);
    rdc(A_CNT_STAT, 32'h5);
    rdc(A_SYS_STAT, 32'h0400_0008);
    sleep <= 1'b0;
    tk(2);
    #1 cmp({31'h0, wake}, 32'h0);
    wrr(A_SYS_STAT, 32'hFFFF_FFFF);
    rdc(A_CAUSE, 32'h0);
    // analogue events, then accumulation mode
    ap <= 5'h1F;
    tk(1);
    ap <= 5'h0;
    tk(2);
    rdc(A_AP_STAT, 32'h1D);
    wrr(A_AP_STAT, 32'h1F);
    wrr(A_AP_MODE, 32'h1);
    ap <= 5'h02;
    tk(1);
    ap <= 5'h0;
    tk(2);
    rdc(A_AP_STAT, 32'h2);
    // timer 0 rising enabled, then period end
    wrr(A_TMR_EN, 32'h2);
    // first pass rise only, second pass period end on top of sticky rise
    for (int i = 0; i < 2; i++)
    begin
      tmr <= 2'b01;
      tk(2);
      tmr <= 2'b00;
      tk(2);
      rdc(A_TMR_STAT0, {30'h0, 1'b1, i[0]});
      cmp({28'h0, irq}, 32'h4);
      wrr(A_TMR_EN, 32'h1);
    end
    tally_and_finish();
  end
endmodule
